//--- pkg/gpp_pkg.sv
// constants, register map and carrier types of the 8-pin general-purpose i/o port
// assumes one 100 MHz clock and an 8-bit register port with one-cycle read latency
package gpp_pkg;

	// port geometry
	localparam int unsigned NUM_PINS     = 8;
	localparam int unsigned NUM_VEC      = 4;
	localparam int unsigned ADDR_W       = 8;
	localparam int unsigned DATA_W       = 8;
	localparam int unsigned SYNC_STAGES  = 2;

	// register offsets
	localparam logic [7:0] OFS_DATA      = 8'h00;
	localparam logic [7:0] OFS_DIR       = 8'h01;
	localparam logic [7:0] OFS_OPT       = 8'h02;
	localparam logic [7:0] OFS_SENSE     = 8'h03;
	localparam logic [7:0] OFS_SEL       = 8'h04;
	localparam logic [7:0] OFS_PEND      = 8'h05;

	// reset values and the read value of unmapped places
	localparam logic [7:0] RST_DATA      = 8'hff;
	localparam logic [7:0] RST_DIR       = 8'h00;
	localparam logic [7:0] RST_OPT       = 8'h40;
	localparam logic [3:0] RST_SENSE     = 4'h0;
	localparam logic [7:0] RST_SEL       = 8'h00;
	localparam logic [7:0] RD_UNMAPPED   = 8'h00;

	// edge sense encoding, one bit per vector
	localparam logic       SENSE_FALL    = 1'b0;
	localparam logic       SENSE_RISE    = 1'b1;

	// what the port drives towards each pad
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
		logic [7:0] pullup_en;
	} gpp_pad_t;

	// output function of an on-chip peripheral on each pin
	typedef struct packed {
		logic [7:0] en;
		logic [7:0] val;
	} gpp_alt_t;

endpackage : gpp_pkg

//--- rtl/gpp_ext_irq.sv
// edge detection and pending latches of the external interrupt vectors
// assumes synchronised pin levels; pins are shared evenly over the vectors
module gpp_ext_irq #(
	parameter int unsigned NP = 8,
	parameter int unsigned NV = 4
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          rst_n,
	// pins
	input  wire logic [NP-1:0] pin_lvl,
	input  wire logic [NP-1:0] pin_irq_en,
	// control
	input  wire logic [NV-1:0] sense_rise,
	input  wire logic [NV-1:0] vec_fetch,
	input  wire logic          sense_clr,
	// requests
	output logic      [NV-1:0] pend_r
);

	localparam int unsigned PPV = NP / NV;

	logic [NP-1:0] prev_r;
	logic          arm_r;
	logic [NP-1:0] hit;
	logic [NV-1:0] set_v;
	logic [NV-1:0] pend_nxt;

	// qualifying edge per pin, by the sense bit of its vector
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			hit[p] = pin_irq_en[p] && arm_r &&
				((sense_rise[p / PPV] == gpp_pkg::SENSE_RISE) ?
				 (pin_lvl[p] && !prev_r[p]) : (!pin_lvl[p] && prev_r[p]));
		end
	end

	// gather pin hits into their vectors
	genvar v;
	generate
		for (v = 0; v < NV; v++) begin : g_vec
			assign set_v[v] = |hit[v*PPV +: PPV];
		end
	endgenerate

	// a new edge wins over fetch or sense-change clear
	assign pend_nxt = set_v | (pend_r & ~(vec_fetch | {NV{sense_clr}}));

	// edge history; arm blocks a false edge on the first cycle out of reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= '0;
			arm_r  <= 1'b0;
			pend_r <= '0;
		end else begin
			prev_r <= pin_lvl;
			arm_r  <= 1'b1;
			pend_r <= pend_nxt;
		end
	end

endmodule // gpp_ext_irq

//--- rtl/gpp_port.sv
// 8-pin general-purpose i/o port: data latch, direction, option bits,
// peripheral override and external interrupt inputs
// assumes pads resolved outside from out/oe_n/pullup_en, and a cpu that
// pulses vec_fetch for one cycle when it fetches an external vector

// What this block does
// - every pin configured by its own bits
// - input direction reads the pin level
// - input mode writes touch only latch
// - input option bit selects pull-up
// - option on select pin enables interrupt
// - each vector has rising or falling sense
// - vector fetch clears request latch
// - sense change clears all pending requests
// - output drives latch, reads latch back
// - output option selects push-pull or open-drain
// - zero drives low, one high or floats
// - peripheral output overrides port settings
// - input plus peripheral output reads peripheral
// - output pin feeds latch to peripheral
// - low power leaves port; interrupts wake
// - interrupt reaches cpu only when unmasked
// - direction/option encode the four modes
module gpp_port (
	// clock and reset
	input  wire logic                clock,
	input  wire logic                rst_n,
	// register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [7:0]          reg_rdata,
	// pads
	input  wire logic [7:0]          pad_in,
	output gpp_pkg::gpp_pad_t        pad_drive,
	// on-chip peripherals
	input  wire gpp_pkg::gpp_alt_t   alt_out,
	output logic      [7:0]          alt_in_val,
	// cpu interrupt side
	input  wire logic                cc_irq_mask,
	input  wire logic [3:0]          vec_fetch,
	output logic      [3:0]          ext_irq_req,
	output logic                     wake_req
);

	// register file
	logic [7:0] data_r;
	logic [7:0] data_nxt;
	logic [7:0] dir_r;
	logic [7:0] dir_nxt;
	logic [7:0] opt_r;
	logic [7:0] opt_nxt;
	logic [3:0] sense_r;
	logic [3:0] sense_nxt;
	logic [7:0] sel_r;
	logic [7:0] sel_nxt;
	logic [7:0] rdata_nxt;

	// decode and pin state
	logic       wr_data;
	logic       wr_dir;
	logic       wr_opt;
	logic       wr_sense;
	logic       wr_sel;
	logic       sense_clr;
	logic [7:0] pin_sync;
	logic [7:0] port_rd_val;
	logic [7:0] is_in;
	logic [7:0] irq_en;
	logic [3:0] pend;
	gpp_pkg::gpp_pad_t pad_nxt;

	// one write strobe per register
	function automatic logic hit_ofs(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	assign wr_data  = reg_wr && hit_ofs(reg_addr, gpp_pkg::OFS_DATA);
	assign wr_dir   = reg_wr && hit_ofs(reg_addr, gpp_pkg::OFS_DIR);
	assign wr_opt   = reg_wr && hit_ofs(reg_addr, gpp_pkg::OFS_OPT);
	assign wr_sense = reg_wr && hit_ofs(reg_addr, gpp_pkg::OFS_SENSE);
	assign wr_sel   = reg_wr && hit_ofs(reg_addr, gpp_pkg::OFS_SEL);

	// a data write only ever lands in the latch; pins follow only when output
	assign data_nxt  = wr_data ? reg_wdata : data_r;
	assign dir_nxt   = wr_dir  ? reg_wdata : dir_r;
	assign opt_nxt   = wr_opt  ? reg_wdata : opt_r;
	assign sel_nxt   = wr_sel  ? reg_wdata : sel_r;
	assign sense_nxt = wr_sense ? reg_wdata[3:0] : sense_r;

	// only a real change of sense drops pending requests
	assign sense_clr = wr_sense && (reg_wdata[3:0] != sense_r);

	// configuration registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_r  <= gpp_pkg::RST_DATA;
			dir_r   <= gpp_pkg::RST_DIR;
			opt_r   <= gpp_pkg::RST_OPT;
			sense_r <= gpp_pkg::RST_SENSE;
			sel_r   <= gpp_pkg::RST_SEL;
		end else begin
			data_r  <= data_nxt;
			dir_r   <= dir_nxt;
			opt_r   <= opt_nxt;
			sense_r <= sense_nxt;
			sel_r   <= sel_nxt;
		end
	end

	// pad levels synchronised before any use
	gpp_sync #(
		.WIDTH    (gpp_pkg::NUM_PINS)
	) u_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in (pad_in),
		.sync_out (pin_sync)
	);

	// direction zero means input
	assign is_in = ~dir_r;

	// data read: latch when output, peripheral value when overridden, else pin
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_pin
			assign port_rd_val[i] = dir_r[i]         ? data_r[i] :
			                        alt_out.en[i]    ? alt_out.val[i] :
			                                           pin_sync[i];
			// peripheral input sees latch when the pin is an output
			assign alt_in_val[i]  = dir_r[i] ? data_r[i] : pin_sync[i];
			// pad drive per pin
			assign pad_nxt.out[i] = alt_out.en[i] ? alt_out.val[i] : data_r[i];
			assign pad_nxt.oe_n[i] = alt_out.en[i] ? 1'b0 :
			                         is_in[i]      ? 1'b1 :
			                         opt_r[i]      ? 1'b0 :
			                                         data_r[i];
			assign pad_nxt.pullup_en[i] = is_in[i] && opt_r[i] && !alt_out.en[i];
			// interrupt input: input direction, option set, pin selected
			assign irq_en[i] = is_in[i] && opt_r[i] && sel_r[i];
		end
	endgenerate

	// registered pad drive so outputs come from flip-flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pad_drive.out       <= 8'h00;
			pad_drive.oe_n      <= 8'hff;
			pad_drive.pullup_en <= 8'h00;
		end else begin
			pad_drive <= pad_nxt;
		end
	end

	// external interrupt vectors
	gpp_ext_irq #(
		.NP         (gpp_pkg::NUM_PINS),
		.NV         (gpp_pkg::NUM_VEC)
	) u_irq (
		.clock      (clock),
		.rst_n      (rst_n),
		.pin_lvl    (pin_sync),
		.pin_irq_en (irq_en),
		.sense_rise (sense_r),
		.vec_fetch  (vec_fetch),
		.sense_clr  (sense_clr),
		.pend_r     (pend)
	);

	// cpu sees requests only while its mask bit is clear; wake ignores the mask
	assign ext_irq_req = pend & {4{!cc_irq_mask}};
	assign wake_req    = |pend;

	// read mux
	always_comb begin
		rdata_nxt = gpp_pkg::RD_UNMAPPED;
		unique case (reg_addr)
			gpp_pkg::OFS_DATA:  rdata_nxt = port_rd_val;
			gpp_pkg::OFS_DIR:   rdata_nxt = dir_r;
			gpp_pkg::OFS_OPT:   rdata_nxt = opt_r;
			gpp_pkg::OFS_SENSE: rdata_nxt = {4'h0, sense_r};
			gpp_pkg::OFS_SEL:   rdata_nxt = sel_r;
			gpp_pkg::OFS_PEND:  rdata_nxt = {4'h0, pend};
			default:            rdata_nxt = gpp_pkg::RD_UNMAPPED;
		endcase
	end

	// read data stands only the cycle after the strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
		end
	end

endmodule // gpp_port

//--- rtl/gpp_sync.sv
// two-stage synchroniser for a bus of independent levels
// assumes every bit is an unrelated asynchronous level, never a word
module gpp_sync #(
	parameter int unsigned WIDTH = 8
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule // gpp_sync

//--- testbench/gpp_pads.sv
// board model of the eight pads: device drive, board drive, pull-up
// assumes pad_drive from the port and board drive from the bench
module gpp_pads (
	// clock
	input wire logic			clock,
	// device side
	input wire gpp_pkg::gpp_pad_t		pad_drive,
	// board side
	input wire logic [7:0]			board_en,
	input wire logic [7:0]			board_val,
	output logic [7:0]			pad_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]	last_r = 8'h00;
	// a floating pad shows the inverse of its last level
	always_ff @(posedge clock) begin
		last_r <= pad_in;
	end
	// device drive wins, then board, then pull-up
	assign pad_in = (~pad_drive.oe_n & pad_drive.out)
		| (pad_drive.oe_n & board_en & board_val)
		| (pad_drive.oe_n & ~board_en & (pad_drive.pullup_en | ~last_r));
endmodule // gpp_pads

//--- testbench/gpp_port_monitor.sv
// concurrent checks of the port's pad, register and interrupt relations
// assumes it is bound to gpp_port and sees its ports only
module gpp_port_monitor (
	// clock and reset
	input wire logic			clock,
	input wire logic			rst_n,
	// register port
	input wire logic [7:0]			reg_addr,
	input wire logic [7:0]			reg_wdata,
	input wire logic			reg_wr,
	input wire logic			reg_rd,
	input wire logic [7:0]			reg_rdata,
	// pads
	input wire logic [7:0]			pad_in,
	input wire gpp_pkg::gpp_pad_t		pad_drive,
	input wire gpp_pkg::gpp_alt_t		alt_out,
	// interrupt side
	input wire logic			cc_irq_mask,
	input wire logic [3:0]			vec_fetch,
	input wire logic [3:0]			ext_irq_req,
	input wire logic			wake_req
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [7:0]	dat_r, dir_r, opt_r, pin_r;
	logic [3:0]	sns_r;
	logic [2:0]	calm_r;
	logic [1:0]	live_r;
	// expected pad drive from the shadowed registers
	wire		wsel = reg_wr && reg_addr == gpp_pkg::OFS_SENSE;
	wire		calm = calm_r == 3'h7;
	wire [7:0]	exp_oe = ~alt_out.en & (~dir_r | (~opt_r & dat_r));
	wire [7:0]	exp_out = (alt_out.en & alt_out.val) | (~alt_out.en & dat_r);
	// shadow writes; count cycles with steady pads
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{dat_r, dir_r, opt_r} <= {gpp_pkg::RST_DATA, gpp_pkg::RST_DIR, gpp_pkg::RST_OPT};
			{sns_r, pin_r, calm_r, live_r} <= '0;
		end else begin
			if (reg_wr && reg_addr == gpp_pkg::OFS_DATA) dat_r <= reg_wdata;
			if (reg_wr && reg_addr == gpp_pkg::OFS_DIR) dir_r <= reg_wdata;
			if (reg_wr && reg_addr == gpp_pkg::OFS_OPT) opt_r <= reg_wdata;
			if (wsel) sns_r <= reg_wdata[3:0];
			pin_r <= pad_in;
			calm_r <= (pad_in != pin_r) ? 3'h0 : (calm ? calm_r : calm_r + 3'h1);
			live_r <= {live_r[0], 1'b1};
		end
	end
	pad_enable_a: assert property (live_r[1] |-> pad_drive.oe_n == $past(exp_oe))
		else $error("pad enable differs from registers");
	pad_level_a: assert property (live_r[1] |->
		(pad_drive.out & ~pad_drive.oe_n) == $past(exp_out & ~exp_oe))
		else $error("driven pad level differs from latch");
	read_dir_a: assert property (reg_rd && reg_addr == gpp_pkg::OFS_DIR |=>
		reg_rdata == $past(dir_r))
		else $error("direction readback wrong");
	read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	irq_mask_a: assert property (cc_irq_mask |-> ext_irq_req == 4'h0)
		else $error("request passed the mask");
	wake_req_a: assert property (ext_irq_req != 4'h0 |-> wake_req)
		else $error("request without wake");
	fetch_clear_a: assert property (vec_fetch != 4'h0 && calm |=>
		(ext_irq_req & $past(vec_fetch)) == 4'h0)
		else $error("fetch left request pending");
	sense_clear_a: assert property (wsel && reg_wdata[3:0] != sns_r && calm |=> !wake_req)
		else $error("sense change left request pending");
	cover property (ext_irq_req != 4'h0);
	cover property (vec_fetch != 4'h0 && wake_req);
	cover property (alt_out.en != 8'h00 && reg_rd);
endmodule // gpp_port_monitor

bind gpp_port gpp_port_monitor i_gpp_port_monitor (.clock(clock), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pad_in(pad_in), .pad_drive(pad_drive), .alt_out(alt_out),
	.cc_irq_mask(cc_irq_mask), .vec_fetch(vec_fetch), .ext_irq_req(ext_irq_req),
	.wake_req(wake_req));

//--- testbench/gpp_port_tb.sv
// self-checking bench of the port with a board model on the pads
// assumes one-cycle read data and registered pad drive
module gpp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic			clock = 1'b0;
	logic			rst_n = 1'b0;
	logic [7:0]		reg_addr = 8'h00;
	logic [7:0]		reg_wdata = 8'h00;
	logic			reg_wr = 1'b0;
	logic			reg_rd = 1'b0;
	logic [7:0]		board_en = 8'hff;
	logic [7:0]		board_val = 8'hff;
	logic			cc_irq_mask = 1'b0;
	logic [3:0]		vec_fetch = 4'h0;
	gpp_pkg::gpp_alt_t	alt_out = '0;
	gpp_pkg::gpp_pad_t	pad_drive;
	logic [7:0]		reg_rdata, pad_in, alt_in_val;
	logic [3:0]		ext_irq_req;
	logic			wake_req;
	int			num_errors = 0;
	int			tests_run = 0;
	// 100 MHz clock
	always #5 clock = ~clock;
	gpp_port i_gpp_port (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pad_in(pad_in), .pad_drive(pad_drive), .alt_out(alt_out), .alt_in_val(alt_in_val),
		.cc_irq_mask(cc_irq_mask), .vec_fetch(vec_fetch), .ext_irq_req(ext_irq_req),
		.wake_req(wake_req));
	gpp_pads i_gpp_pads (.clock(clock), .pad_drive(pad_drive), .board_en(board_en),
		.board_val(board_val), .pad_in(pad_in));
	task automatic chk(input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic close_out;
		if (num_errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// register bus cycles; read data judged in their one cycle
	task automatic wr(input logic [7:0] a, d);
		@(posedge clock);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge clock);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic pads(input logic [7:0] v);
		@(posedge clock);
		board_val <= v;
	endtask
	task automatic settle;
		repeat (4) @(posedge clock);
		#1;
	endtask
	task automatic wait_irq;
		int n = 0;
		while (ext_irq_req[0] !== 1'b1 && n < 20) begin
			@(posedge clock);
			#1 n++;
		end
		if (ext_irq_req[0] !== 1'b1) begin
			num_errors++;
			close_out;
		end
	endtask
	// reset values, unmapped and read-only places
	task automatic t_reset;
		logic [7:0] a[7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h05};
		logic [7:0] e[7] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		wr(8'h07, 8'hff);
		wr(gpp_pkg::OFS_PEND, 8'hff);
		for (int i = 0; i < 7; i++) begin
			rd(a[i], e[i]);
		end
		chk(pad_drive.oe_n, 8'hff);
	endtask
	// push-pull low nibble, open-drain high nibble
	task automatic t_output;
		wr(gpp_pkg::OFS_DATA, 8'h5a);
		wr(gpp_pkg::OFS_OPT, 8'h0f);
		wr(gpp_pkg::OFS_DIR, 8'hff);
		pads(8'h00);
		settle;
		chk(pad_drive.oe_n, 8'h50);
		chk(pad_in, 8'h0a);
		chk(alt_in_val, 8'h5a);
		rd(gpp_pkg::OFS_DATA, 8'h5a);
	endtask
	// input pins read the pad; writes stay in the latch
	task automatic t_input;
		wr(gpp_pkg::OFS_DIR, 8'h00);
		wr(gpp_pkg::OFS_OPT, 8'h00);
		pads(8'h3c);
		settle;
		rd(gpp_pkg::OFS_DATA, 8'h3c);
		chk(alt_in_val, 8'h3c);
		wr(gpp_pkg::OFS_DATA, 8'h81);
		wr(gpp_pkg::OFS_OPT, 8'h0f);
		settle;
		chk(pad_drive.oe_n, 8'hff);
		chk(pad_drive.pullup_en, 8'h0f);
		rd(gpp_pkg::OFS_DATA, 8'h3c);
		wr(gpp_pkg::OFS_DIR, 8'hff);
		settle;
		chk(pad_drive.oe_n, 8'h80);
		chk(pad_in, 8'h01);
	endtask
	// peripheral output takes the low nibble of input pins
	task automatic t_alt;
		wr(gpp_pkg::OFS_DIR, 8'h00);
		wr(gpp_pkg::OFS_OPT, 8'h00);
		alt_out <= '{en: 8'h0f, val: 8'h05};
		settle;
		chk(pad_drive.oe_n, 8'hf0);
		rd(gpp_pkg::OFS_DATA, 8'h35);
		@(posedge clock);
		alt_out <= '0;
	endtask
	// edges, mask, fetch and sense change on vector 0
	task automatic t_irq;
		wr(gpp_pkg::OFS_OPT, 8'h05);
		wr(gpp_pkg::OFS_SEL, 8'h01);
		pads(8'hff);
		settle;
		pads(8'hfa);
		wait_irq;
		settle;
		chk({4'h0, ext_irq_req}, 8'h01);
		@(posedge clock);
		cc_irq_mask <= 1'b1;
		#1 chk({3'h0, wake_req, ext_irq_req}, 8'h10);
		@(posedge clock);
		{cc_irq_mask, vec_fetch} <= {1'b0, 4'h1};
		@(posedge clock);
		vec_fetch <= 4'h0;
		#1 chk({3'h0, wake_req, ext_irq_req}, 8'h00);
		pads(8'hff);
		settle;
		pads(8'hfa);
		wait_irq;
		settle;
		wr(gpp_pkg::OFS_SENSE, 8'h01);
		#1 chk({3'h0, wake_req, ext_irq_req}, 8'h00);
		pads(8'hfb);
		wait_irq;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		t_reset;
		t_output;
		t_input;
		t_alt;
		t_irq;
		close_out;
	end
	// cut a hung run short
	initial begin
		#100us;
		num_errors++;
		close_out;
	end
endmodule // gpp_port_tb
